/* File: verilog/cpo_dev.sv */
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cpo_dev #(
   parameter int unsigned MS_CYCLES = cpo_pkg::CYC_PER_MS
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   cpo_link_if.dev                       link,
   input  wire logic [6:0]               node_id,
   input  wire logic                     sync_en,
   input  wire logic [cpo_pkg::IN_W-1:0] din,
   output logic [cpo_pkg::OUT_W-1:0]     dout,
   output logic [3:0]                    baud_sel
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic                     booted;
      logic [6:0]               id;
      logic [3:0]               baud;
      logic [3:0]               baud_pend;
      logic [3:0]               sdo2_fc;
      logic [15:0]              evt;
      logic [15:0]              ms_left;
      logic [15:0]              cyc;
      logic [cpo_pkg::IN_W-1:0]  last;
      logic [cpo_pkg::IN_W-1:0]  tx_data;
      logic                     tx_valid;
      logic                     pend;
      logic [cpo_pkg::OUT_W-1:0] out_pend;
      logic [cpo_pkg::OUT_W-1:0] dout;
   } cpo_dev_st_t;

   cpo_dev_st_t s_r;
   cpo_dev_st_t s_nxt;

   // ****************************************************************
   // Received frame decode
   // ****************************************************************
   logic [3:0]  rx_fc;
   logic [6:0]  rx_nid;
   logic        rx_rtr;
   logic [3:0]  rx_dlc;
   logic [63:0] rx_d;
   logic        for_me;
   logic        bcast;
   logic        rtr_req;
   logic        sync_req;
   logic        rxpdo;
   logic        sdo_wr;
   logic        nmt_rst;
   logic [15:0] sdo_idx;
   logic [7:0]  sdo_sub;
   logic [31:0] sdo_val;

   assign rx_fc  = link.m2s_id[15:12];
   assign rx_nid = {link.m2s_id[11:8], link.m2s_id[7:5]};
   assign rx_rtr = link.m2s_id[4];
   assign rx_dlc = link.m2s_id[3:0];
   assign rx_d   = link.m2s_data;

   // Frames are always consumed; nothing on the link is buffered
   assign link.m2s_ready = 1'b1;

   assign for_me = link.m2s_valid && s_r.booted && rx_nid == s_r.id
                   && rx_dlc <= cpo_pkg::MAX_DLC;
   assign bcast  = link.m2s_valid && s_r.booted && rx_nid == 7'h00
                   && rx_dlc <= cpo_pkg::MAX_DLC;

   assign rtr_req = for_me && rx_fc == cpo_pkg::FC_TXPDO && !rx_rtr;

   assign sync_req = bcast && sync_en && rx_fc == cpo_pkg::FC_SYNC && rx_rtr
                     && rx_dlc == 4'h0;

   assign rxpdo = for_me && rx_fc == cpo_pkg::FC_RXPDO && rx_rtr
                  && rx_dlc >= cpo_pkg::OUT_DLC;

   assign sdo_wr = for_me && rx_rtr && rx_dlc == cpo_pkg::MAX_DLC
                   && (rx_fc == cpo_pkg::FC_SDO1 || rx_fc == s_r.sdo2_fc)
                   && rx_d[7:0] == cpo_pkg::SDO_CMD_WR;
   assign sdo_idx = rx_d[23:8];
   assign sdo_sub = rx_d[31:24];
   assign sdo_val = rx_d[63:32];

   assign nmt_rst = bcast && rx_fc == cpo_pkg::FC_NMT
                    && rx_d[7:0] == cpo_pkg::NMT_RESET
                    && (rx_d[15:8] == 8'h00 || rx_d[15:8] == {1'b0, s_r.id});

   // ****************************************************************
   // Send triggers
   // ****************************************************************
   logic tick;
   logic evt_fire;
   logic chg;
   logic want;
   logic free;

   assign tick = s_r.cyc == 16'h0000;

   assign evt_fire = tick && s_r.evt != 16'h0000 && s_r.ms_left <= 16'h0001;

   assign chg = s_r.booted && !sync_en && din != s_r.last;

   // Requests seen while a frame is still waiting are kept in pend
   assign want = s_r.pend | rtr_req | sync_req | evt_fire | chg;
   assign free = !s_r.tx_valid || link.s2m_ready;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_nxt = s_r;
      if (!s_r.booted) begin
         s_nxt.booted = 1'b1;
         s_nxt.id     = node_id;
      end
      // Millisecond divider
      s_nxt.cyc = tick ? 16'(MS_CYCLES - 1) : s_r.cyc - 16'h0001;
      if (tick && s_r.evt != 16'h0000) begin
         s_nxt.ms_left = evt_fire ? s_r.evt : s_r.ms_left - 16'h0001;
      end
      if (s_r.tx_valid && link.s2m_ready) begin
         s_nxt.tx_valid = 1'b0;
      end
      s_nxt.pend = want;
      if (want && free && s_r.booted) begin
         s_nxt.tx_valid = 1'b1;
         s_nxt.tx_data  = din;
         s_nxt.last     = din;
         s_nxt.pend     = 1'b0;
         s_nxt.ms_left  = s_r.evt;
      end
      // Output byte fixed to byte 0
      if (rxpdo) begin
         s_nxt.out_pend = rx_d[cpo_pkg::OUT_W-1:0];
         if (!sync_en) begin
            s_nxt.dout = rx_d[cpo_pkg::OUT_W-1:0];
         end
      end
      if (sync_req) begin
         s_nxt.dout = s_r.out_pend;
      end
      if (sdo_wr) begin
         if (sdo_idx == cpo_pkg::OBJ_BAUD) begin
            s_nxt.baud_pend = sdo_val[3:0];
         end
         if (sdo_idx == cpo_pkg::OBJ_SDO2 && sdo_sub == cpo_pkg::SUB_SDO2_COB) begin
            s_nxt.sdo2_fc = sdo_val[10:7];
         end
         // Type stays fixed; only timer writable
         if (sdo_idx == cpo_pkg::OBJ_TPDO_COMM && sdo_sub == cpo_pkg::SUB_EVT) begin
            s_nxt.evt     = sdo_val[15:0];
            s_nxt.ms_left = sdo_val[15:0];
         end
      end
      if (nmt_rst) begin
         s_nxt.baud = s_r.baud_pend;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r           <= '0;
         s_r.baud      <= cpo_pkg::BAUD_RST;
         s_r.baud_pend <= cpo_pkg::BAUD_RST;
         s_r.sdo2_fc   <= cpo_pkg::SDO2_FC_RST;
         s_r.evt       <= cpo_pkg::EVT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Identifier from latched ID
   cpo_id_pack u_tx_id (
      .fc   (cpo_pkg::FC_TXPDO),
      .node (s_r.id),
      .rtr  (1'b1),
      .dlc  (cpo_pkg::IN_DLC),
      .id   (link.s2m_id)
   );

   assign link.s2m_valid = s_r.tx_valid;
   assign link.s2m_data  = {40'h00_0000_0000, s_r.tx_data};
   assign dout           = s_r.dout;
   assign baud_sel       = s_r.baud;

endmodule : cpo_dev
`default_nettype wire

/* File: verilog/cpo_pkg.sv */
package cpo_pkg;

   // ****************************************************************
   // Function codes
   // ****************************************************************
   localparam logic [3:0] FC_NMT      = 4'h0;
   localparam logic [3:0] FC_EMCY     = 4'h1;
   localparam logic [3:0] FC_SYNC     = 4'h1;
   localparam logic [3:0] FC_TXPDO    = 4'h3;
   localparam logic [3:0] FC_RXPDO    = 4'h4;
   localparam logic [3:0] FC_SDO1     = 4'hB;
   localparam logic [3:0] FC_GUARD    = 4'hE;
   localparam logic [3:0] SDO2_FC_RST = 4'hC;

   // ****************************************************************
   // Object directory entries
   // ****************************************************************
   localparam logic [15:0] OBJ_BAUD      = 16'h2001;
   localparam logic [15:0] OBJ_SDO2      = 16'h1201;
   localparam logic [15:0] OBJ_TPDO_COMM = 16'h1800;
   localparam logic [7:0]  SUB_SDO2_COB  = 8'h01;
   localparam logic [7:0]  SUB_TTYPE     = 8'h02;
   localparam logic [7:0]  SUB_EVT       = 8'h05;
   localparam logic [7:0]  TTYPE_FIXED   = 8'hFF;
   localparam logic [7:0]  SDO_CMD_WR    = 8'h23;
   localparam logic [7:0]  NMT_RESET     = 8'h81;
   localparam logic [3:0]  BAUD_RST      = 4'h0;
   localparam logic [15:0] EVT_RST       = 16'h0000;

   // ****************************************************************
   // Frame layout
   // ****************************************************************
   localparam int          IN_W    = 24;
   localparam int          OUT_W   = 8;
   localparam logic [3:0]  IN_DLC  = 4'h3;
   localparam logic [3:0]  OUT_DLC = 4'h1;
   localparam logic [3:0]  MAX_DLC = 4'h8;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_NS     = 20;
   localparam int unsigned MS_NS      = 1000000;
   localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;

   // ****************************************************************
   // Controller registers (APB byte offsets)
   // ****************************************************************
   localparam logic [7:0] OFF_CMD     = 8'h00;
   localparam logic [7:0] OFF_NODE    = 8'h04;
   localparam logic [7:0] OFF_OUTDATA = 8'h08;
   localparam logic [7:0] OFF_SDOADDR = 8'h0C;
   localparam logic [7:0] OFF_SDOVAL  = 8'h10;
   localparam logic [7:0] OFF_STATUS  = 8'h14;
   localparam logic [7:0] OFF_INDATA  = 8'h18;
   localparam int         CMD_OUT     = 0;
   localparam int         CMD_RTR     = 1;
   localparam int         CMD_SYNC    = 2;
   localparam int         CMD_SDO     = 3;
   localparam int         CMD_NMT     = 4;

endpackage : cpo_pkg

/* File: verilog/cpo_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cpo_link_if;
   logic        m2s_valid;
   logic        m2s_ready;
   logic [15:0] m2s_id;
   logic [63:0] m2s_data;
   logic        s2m_valid;
   logic        s2m_ready;
   logic [15:0] s2m_id;
   logic [63:0] s2m_data;

   modport dev (input m2s_valid, m2s_id, m2s_data, s2m_ready,
                output m2s_ready, s2m_valid, s2m_id, s2m_data);
   modport mst (output m2s_valid, m2s_id, m2s_data, s2m_ready,
                input m2s_ready, s2m_valid, s2m_id, s2m_data);
endinterface : cpo_link_if
`default_nettype wire

/* File: verilog/cpo_id_pack.sv */
`timescale 1ns/1ps
`default_nettype none
module cpo_id_pack (
   input  wire logic [3:0]  fc,
   input  wire logic [6:0]  node,
   input  wire logic        rtr,
   input  wire logic [3:0]  dlc,
   output logic      [15:0] id
);
   assign id = {fc, node[6:3], node[2:0], rtr, dlc};
endmodule : cpo_id_pack
`default_nettype wire

/* File: verilog/cpo_mst.sv */
`timescale 1ns/1ps
`default_nettype none
module cpo_mst (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   cpo_link_if.mst          link
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [6:0]               node;
      logic [cpo_pkg::OUT_W-1:0] outdata;
      logic [23:0]              sdo_addr;
      logic [31:0]              sdo_val;
      logic                     tx_valid;
      logic [15:0]              tx_id;
      logic [63:0]              tx_data;
      logic                     in_new;
      logic [cpo_pkg::IN_W-1:0]  indata;
      logic [31:0]              rdata;
      logic                     err;
   } cpo_mst_st_t;

   cpo_mst_st_t s_r;
   cpo_mst_st_t s_nxt;

   logic        mapped;
   logic        wr;
   logic        got;
   logic [31:0] rmux;
   logic [15:0] id_out;
   logic [15:0] id_rtr;
   logic [15:0] id_sync;
   logic [15:0] id_sdo;
   logic [15:0] id_nmt;

   cpo_id_pack u_out  (.fc(cpo_pkg::FC_RXPDO), .node(s_r.node), .rtr(1'b1),
                       .dlc(cpo_pkg::OUT_DLC), .id(id_out));
   cpo_id_pack u_rtr  (.fc(cpo_pkg::FC_TXPDO), .node(s_r.node), .rtr(1'b0),
                       .dlc(4'h0), .id(id_rtr));
   cpo_id_pack u_sync (.fc(cpo_pkg::FC_SYNC), .node(7'h00), .rtr(1'b1),
                       .dlc(4'h0), .id(id_sync));
   cpo_id_pack u_sdo  (.fc(cpo_pkg::FC_SDO1), .node(s_r.node), .rtr(1'b1),
                       .dlc(cpo_pkg::MAX_DLC), .id(id_sdo));
   cpo_id_pack u_nmt  (.fc(cpo_pkg::FC_NMT), .node(7'h00), .rtr(1'b1),
                       .dlc(4'h2), .id(id_nmt));

   // ****************************************************************
   // APB decode
   // ****************************************************************
   assign mapped = paddr[1:0] == 2'b00 && paddr <= cpo_pkg::OFF_INDATA;
   assign wr     = psel && penable && pwrite && mapped;

   always_comb begin
      rmux = 32'h0000_0000;
      case (paddr)
         cpo_pkg::OFF_NODE:    rmux = {25'h000_0000, s_r.node};
         cpo_pkg::OFF_OUTDATA: rmux = {24'h00_0000, s_r.outdata};
         cpo_pkg::OFF_SDOADDR: rmux = {8'h00, s_r.sdo_addr};
         cpo_pkg::OFF_SDOVAL:  rmux = s_r.sdo_val;
         cpo_pkg::OFF_STATUS:  rmux = {30'h0000_0000, s_r.in_new, s_r.tx_valid};
         cpo_pkg::OFF_INDATA:  rmux = {8'h00, s_r.indata};
         default:              rmux = 32'h0000_0000;
      endcase
   end

   assign got = link.s2m_valid && link.s2m_id[15:12] == cpo_pkg::FC_TXPDO
                && {link.s2m_id[11:8], link.s2m_id[7:5]} == s_r.node
                && link.s2m_id[4];

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_nxt = s_r;
      // Read data and error captured in setup so they come from flops
      if (psel && !penable) begin
         s_nxt.rdata = rmux;
         s_nxt.err   = !mapped;
      end
      if (s_r.tx_valid && link.m2s_ready) begin
         s_nxt.tx_valid = 1'b0;
      end
      if (wr) begin
         case (paddr)
            cpo_pkg::OFF_NODE:    s_nxt.node = pwdata[6:0];
            cpo_pkg::OFF_OUTDATA: s_nxt.outdata = pwdata[cpo_pkg::OUT_W-1:0];
            cpo_pkg::OFF_SDOADDR: s_nxt.sdo_addr = pwdata[23:0];
            cpo_pkg::OFF_SDOVAL:  s_nxt.sdo_val = pwdata;
            default:              s_nxt.node = s_r.node;
         endcase
      end
      // Commands while a frame waits are dropped; poll busy first
      if (wr && paddr == cpo_pkg::OFF_CMD && !s_r.tx_valid) begin
         s_nxt.tx_valid = 1'b1;
         s_nxt.tx_data  = 64'h0000_0000_0000_0000;
         if (pwdata[cpo_pkg::CMD_OUT]) begin
            s_nxt.tx_id        = id_out;
            s_nxt.tx_data[7:0] = s_r.outdata;
         end else if (pwdata[cpo_pkg::CMD_RTR]) begin
            s_nxt.tx_id = id_rtr;
         end else if (pwdata[cpo_pkg::CMD_SYNC]) begin
            s_nxt.tx_id = id_sync;
         end else if (pwdata[cpo_pkg::CMD_SDO]) begin
            s_nxt.tx_id   = id_sdo;
            s_nxt.tx_data = {s_r.sdo_val, s_r.sdo_addr[7:0], s_r.sdo_addr[23:8],
                             cpo_pkg::SDO_CMD_WR};
         end else if (pwdata[cpo_pkg::CMD_NMT]) begin
            s_nxt.tx_id         = id_nmt;
            s_nxt.tx_data[15:0] = {1'b0, s_r.node, cpo_pkg::NMT_RESET};
         end else begin
            s_nxt.tx_valid = 1'b0;
         end
      end
      // A new input frame wins over a write-one clear
      if (wr && paddr == cpo_pkg::OFF_STATUS && pwdata[1]) begin
         s_nxt.in_new = 1'b0;
      end
      if (got) begin
         s_nxt.in_new = 1'b1;
         s_nxt.indata = link.s2m_data[cpo_pkg::IN_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata         = s_r.rdata;
   assign pslverr        = s_r.err;
   assign pready         = 1'b1;
   assign link.m2s_valid = s_r.tx_valid;
   assign link.m2s_id    = s_r.tx_id;
   assign link.m2s_data  = s_r.tx_data;
   assign link.s2m_ready = 1'b1;

endmodule : cpo_mst
`default_nettype wire

/* File: bench/cpo_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cpo_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        m2s_valid,
   input wire logic        m2s_ready,
   input wire logic [15:0] m2s_id,
   input wire logic [63:0] m2s_data,
   input wire logic        s2m_valid,
   input wire logic        s2m_ready,
   input wire logic [15:0] s2m_id,
   input wire logic [63:0] s2m_data,
   input wire logic [6:0]  node_id,
   input wire logic        sync_en,
   input wire logic [23:0] din,
   input wire logic [7:0]  dout,
   input wire logic [3:0]  baud_sel
);
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   logic       m_tk;
   logic       out_tk;
   logic       nmt_tk;
   logic [7:0] out_q_r;
   assign m_tk = m2s_valid && m2s_ready;
   assign out_tk = m_tk && !sync_en && m2s_id[15:5] == 11'h200 + {4'h0, node_id};
   assign nmt_tk = m_tk && m2s_id[15:12] == cpo_pkg::FC_NMT
                   && m2s_data[7:0] == cpo_pkg::NMT_RESET;
   // Last output byte seen on the wire with sync off, compared with dout later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q_r <= 8'h00;
      end else if (out_tk) begin
         out_q_r <= m2s_data[7:0];
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   tx_ident_a: assert property (
      s2m_valid |-> s2m_id[15:5] == 11'h180 + {4'h0, node_id})
      else $error("input frame identifier wrong");
   tx_hdr_a: assert property (
      s2m_valid |-> s2m_id[4:0] == {1'b1, cpo_pkg::IN_DLC})
      else $error("input frame flag or length wrong");
   tx_len_a: assert property (
      s2m_valid |-> s2m_data[63:24] == '0)
      else $error("input frame carries stray bytes");
   rx_dlc_a: assert property (
      m2s_valid |-> m2s_id[3:0] <= cpo_pkg::MAX_DLC)
      else $error("request frame too long");
   rx_once_a: assert property (
      m2s_valid && m2s_ready |=> !m2s_valid)
      else $error("request frame repeated");
   evt_send_a: assert property (
      !sync_en && $changed(din) |=> s2m_valid && s2m_data[23:0] == $past(din))
      else $error("input change not sent");
   poll_reply_a: assert property (
      m_tk && m2s_id == {cpo_pkg::FC_TXPDO, node_id, 5'h00} |-> ##[1:2] s2m_valid)
      else $error("remote request not answered");
   sync_send_a: assert property (
      m_tk && sync_en && m2s_id == {cpo_pkg::FC_SYNC, 7'h00, 1'b1, 4'h0}
      |-> ##[1:2] s2m_valid)
      else $error("sync did not send inputs");
   sync_hold_a: assert property (
      sync_en && $past(sync_en) && !$past(m2s_valid) && !$past(m2s_valid, 2)
      |-> $stable(dout))
      else $error("outputs moved without sync");
   out_apply_a: assert property (
      $past(out_tk, 2) |-> dout == out_q_r)
      else $error("output byte not applied");
   baud_hold_a: assert property (
      $changed(baud_sel) |-> $past(nmt_tk) || $past(nmt_tk, 2))
      else $error("baud changed without reset");
endmodule : cpo_checker
`default_nettype wire

/* File: bench/canopen_pdo_message_handler_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module canopen_pdo_message_handler_bench;
   localparam int MSC = 20;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serr;
   logic [6:0]  node_id = 7'h25;
   logic        sync_en = 1'b0;
   logic [23:0] din = 24'h00_0000;
   logic [7:0]  dout;
   logic [3:0]  baud_sel;
   logic [15:0] tx_id;
   logic [15:0] rx_id;
   logic [63:0] tx_dat;
   logic [63:0] rx_dat;
   int          cyc = 0;
   int          n_tx = 0;
   int          t_prev = 0;
   int          t_last = 0;
   int          checks = 0;
   int          n_fail = 0;

   always #10 pclk = ~pclk;

   cpo_link_if lnk ();
   cpo_mst cpo_mst_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(lnk.mst));
   cpo_dev #(.MS_CYCLES(MSC)) cpo_dev_inst (.pclk(pclk), .presetn(presetn),
      .link(lnk.dev), .node_id(node_id), .sync_en(sync_en), .din(din), .dout(dout),
      .baud_sel(baud_sel));
   cpo_checker cpo_checker_inst (.pclk(pclk), .presetn(presetn),
      .m2s_valid(lnk.m2s_valid), .m2s_ready(lnk.m2s_ready), .m2s_id(lnk.m2s_id),
      .m2s_data(lnk.m2s_data), .s2m_valid(lnk.s2m_valid), .s2m_ready(lnk.s2m_ready),
      .s2m_id(lnk.s2m_id), .s2m_data(lnk.s2m_data), .node_id(node_id),
      .sync_en(sync_en), .din(din), .dout(dout), .baud_sel(baud_sel));

   // ****************************************************************
   // Wire monitor and bus tasks
   // ****************************************************************
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (lnk.s2m_valid && lnk.s2m_ready) begin
         n_tx <= n_tx + 1;
         tx_id <= lnk.s2m_id;
         tx_dat <= lnk.s2m_data;
         t_prev <= t_last;
         t_last <= cyc;
      end
      if (lnk.m2s_valid && lnk.m2s_ready) begin
         rx_id <= lnk.m2s_id;
         rx_dat <= lnk.m2s_data;
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   // Busy polling keeps commands from being dropped silently
   task automatic cmd(input int b);
      logic [31:0] q;
      wr(cpo_pkg::OFF_CMD, 32'h0000_0001 << b);
      q = 32'h0000_0001;
      for (int i = 0; i < 50 && q[0]; i++) apb(1'b0, cpo_pkg::OFF_STATUS, 32'h0, q);
      `CHK("busy", 1'b0, q[0])
   endtask : cmd

   task automatic sdo(input logic [23:0] a, input logic [31:0] v);
      wr(cpo_pkg::OFF_SDOADDR, {8'h00, a});
      wr(cpo_pkg::OFF_SDOVAL, v);
      cmd(cpo_pkg::CMD_SDO);
   endtask : sdo

   task automatic finish_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin : main
      logic [31:0] q;
      int          n0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK("baud rst", 4'h0, baud_sel)
      // Node first, or SDO, RTR and output frames go to node zero and are ignored
      wr(cpo_pkg::OFF_NODE, {25'h000_0000, node_id});
      sdo({cpo_pkg::OBJ_BAUD, 8'h00}, 32'h0000_0003);
      `CHK("sdo code", {cpo_pkg::FC_SDO1, node_id, 1'b1}, rx_id[15:4])
      `CHK("sdo data", 64'h0000_0003_0020_0123, rx_dat)
      `CHK("baud held", 4'h0, baud_sel)
      cmd(cpo_pkg::CMD_NMT);
      `CHK("nmt code", 4'h0, rx_id[15:12])
      `CHK("baud new", 4'h3, baud_sel)
      n0 = n_tx;
      din <= 24'hA5_3C96;
      repeat (3) @(posedge pclk);
      `CHK("evt cnt", n0 + 1, n_tx)
      `CHK("evt id", 11'h180 + {4'h0, node_id}, tx_id[15:5])
      `CHK("evt hdr", {1'b1, cpo_pkg::IN_DLC}, tx_id[4:0])
      `CHK("evt dat", {40'h00_0000_0000, 24'hA5_3C96}, tx_dat)
      apb(1'b0, cpo_pkg::OFF_INDATA, 32'h0, q);
      `CHK("indata", 32'h00A5_3C96, q)
      apb(1'b0, cpo_pkg::OFF_STATUS, 32'h0, q);
      `CHK("in new", 1'b1, q[1])
      wr(cpo_pkg::OFF_STATUS, 32'h0000_0002);
      apb(1'b0, cpo_pkg::OFF_STATUS, 32'h0, q);
      `CHK("in clr", 1'b0, q[1])
      apb(1'b0, 8'h1C, 32'h0, q);
      `CHK("unmapped", 33'h0_0000_0001, {q, serr})
      n0 = n_tx;
      cmd(cpo_pkg::CMD_RTR);
      repeat (2) @(posedge pclk);
      `CHK("rtr req", {cpo_pkg::FC_TXPDO, node_id, 5'h00}, rx_id)
      `CHK("rtr cnt", n0 + 1, n_tx)
      `CHK("rtr dat", 24'hA5_3C96, tx_dat[23:0])
      wr(cpo_pkg::OFF_OUTDATA, 32'h0000_005A);
      cmd(cpo_pkg::CMD_OUT);
      repeat (2) @(posedge pclk);
      `CHK("out id", 11'h200 + {4'h0, node_id}, rx_id[15:5])
      `CHK("out flag", 1'b1, rx_id[4])
      `CHK("out evt", 8'h5A, dout)
      sync_en <= 1'b1;
      wr(cpo_pkg::OFF_OUTDATA, 32'h0000_00C3);
      cmd(cpo_pkg::CMD_OUT);
      n0 = n_tx;
      din <= 24'h12_3456;
      repeat (4) @(posedge pclk);
      `CHK("sync out held", 8'h5A, dout)
      `CHK("sync no evt", n0, n_tx)
      cmd(cpo_pkg::CMD_SYNC);
      repeat (2) @(posedge pclk);
      `CHK("sync id", {cpo_pkg::FC_SYNC, 7'h00, 1'b1, 4'h0}, rx_id)
      `CHK("sync out", 8'hC3, dout)
      `CHK("sync dat", 24'h12_3456, tx_dat[23:0])
      `CHK("sync cnt", n0 + 1, n_tx)
      sync_en <= 1'b0;
      sdo({cpo_pkg::OBJ_TPDO_COMM, cpo_pkg::SUB_EVT}, 32'h0000_0002);
      repeat (5 * MSC) @(posedge pclk);
      `CHK("timer gap", 2 * MSC, t_last - t_prev)
      sdo({cpo_pkg::OBJ_TPDO_COMM, cpo_pkg::SUB_EVT}, 32'h0000_0000);
      n0 = n_tx;
      repeat (4 * MSC) @(posedge pclk);
      `CHK("timer off", n0, n_tx)
      // A cyclic type written here must be ignored, events still flow
      sdo({cpo_pkg::OBJ_TPDO_COMM, cpo_pkg::SUB_TTYPE}, 32'h0000_0001);
      n0 = n_tx;
      din <= 24'h65_4321;
      repeat (3) @(posedge pclk);
      `CHK("ttype fixed", n0 + 1, n_tx)
      finish_test();
   end

   // Whole run is well under two thousand cycles
   initial begin : watchdog
      repeat (10000) @(posedge pclk);
      n_fail++;
      finish_test();
   end
endmodule : canopen_pdo_message_handler_bench
`default_nettype wire
